//--- core/lspa_pkg.sv
// Purpose: shared constants and types of the point-level switch and alarm logic
// Assumes: classic Wishbone register access, 32-bit data, byte addresses
// Notes: register map and field layout held here only
package lspa_pkg;
  localparam int CNT_W = 16;
  localparam int PCT_W = 7;

  // Byte offsets of the register words
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RISE = 8'h04;
  localparam logic [7:0] OFS_FALL = 8'h08;
  localparam logic [7:0] OFS_RLO = 8'h0c;
  localparam logic [7:0] OFS_RHI = 8'h10;
  localparam logic [7:0] OFS_ALIM = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam logic [7:0] OFS_ISTAT = 8'h1c;
  localparam logic [7:0] OFS_IMASK = 8'h20;
  localparam logic [7:0] OFS_MENU = 8'h24;

  // Percent figures
  localparam logic [PCT_W-1:0] PCT_ZERO = 7'h00;
  localparam logic [PCT_W-1:0] PCT_FULL = 7'h64;
  localparam logic [PCT_W-1:0] SP_RISE_RST = 7'h37;
  localparam logic [PCT_W-1:0] SP_FALL_RST = 7'h2d;
  localparam logic [PCT_W-1:0] SP_EDGE_MARGIN = 7'h01;
  localparam logic [PCT_W-1:0] RISE_MIN = SP_EDGE_MARGIN;
  localparam logic [PCT_W-1:0] RISE_MAX = PCT_FULL - SP_EDGE_MARGIN;

  localparam logic [CNT_W-1:0] RANGE_LO_RST = 16'h0000;
  localparam logic [CNT_W-1:0] RANGE_HI_RST = 16'h0fff;
  localparam logic [CNT_W-1:0] ALIM_RST = 16'hffff;

  // Interrupt status bits
  localparam int IRQ_N = 4;
  localparam int IRQ_SW_ON = 0;
  localparam int IRQ_SW_OFF = 1;
  localparam int IRQ_DIAGNOSIS_TRIGGER_SELECT = 2;
  localparam int IRQ_ALERT = 3;

  // Control word fields and status word percent field
  localparam int CTRL_TRIG_LO = 0;
  localparam int CTRL_BRK = 2;
  localparam int CTRL_INV = 3;
  localparam int CTRL_FMT_LO = 4;
  localparam int STAT_PCT_LO = 8;

  localparam logic [1:0] CURSOR_LAST = 2'h2;
  localparam logic [3:0] DIGIT_MAX = 4'h9;

  typedef enum logic [1:0] {
    TRIG_OFF = 2'b00, TRIG_DIAGNOSIS_TRIGGER_SELECT = 2'b01, TRIG_LEVEL = 2'b10, TRIG_ALERT = 2'b11
  } lspa_trig_t;

  typedef enum logic [2:0] {
    FMT_NUMERIC = 3'b000, FMT_EN = 3'b001, FMT_DE = 3'b010,
    FMT_FR = 3'b011, FMT_ES = 3'b100, FMT_IT = 3'b101
  } lspa_fmt_t;

  typedef enum logic [2:0] {
    MENU_NONE = 3'b000, MENU_TRIG = 3'b001, MENU_CONTACT = 3'b010,
    MENU_RISE = 3'b011, MENU_FALL = 3'b100, MENU_TEXT = 3'b101
  } lspa_menu_t;

  typedef enum logic [1:0] {
    UI_BROWSE = 2'b00, UI_LIVE = 2'b01, UI_EDIT = 2'b10, UI_SELECT = 2'b11
  } lspa_ui_t;

  localparam logic [2:0] SEL_LIM_TRIG = 3'h3;
  localparam logic [2:0] SEL_LIM_CONTACT = 3'h1;
  localparam logic [2:0] SEL_LIM_TEXT = 3'h5;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } lspa_wb_req_t;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic tempFault;
    logic memFault;
  } lspa_sense_t;

  typedef struct packed {
    logic up;
    logic down;
    logic mode;
  } lspa_keys_t;

  typedef struct packed {
    logic ack;
    logic [31:0] datOut;
    lspa_trig_t trig;
    logic brk;
    logic inv;
    lspa_fmt_t fmt;
    logic [PCT_W-1:0] spRise;
    logic [PCT_W-1:0] spFall;
    logic [CNT_W-1:0] rangeLo;
    logic [CNT_W-1:0] rangeHi;
    logic [CNT_W-1:0] alertLim;
    logic swOn;
    logic alarm;
    logic diagPrev;
    logic alertPrev;
    logic [IRQ_N-1:0] irqStat;
    logic [IRQ_N-1:0] irqMask;
    logic irq;
    lspa_menu_t menu;
    lspa_ui_t ui;
    logic [2:0] selVal;
    logic [1:0] cursor;
    logic [11:0] digits;
    logic [11:0] disp;
    logic scroll;
    logic edit;
  } lspa_state_t;

  localparam lspa_state_t ST_RST = '{
    ack: 1'b0, datOut: 32'h0000_0000, trig: TRIG_DIAGNOSIS_TRIGGER_SELECT, brk: 1'b0, inv: 1'b0,
    fmt: FMT_NUMERIC, spRise: SP_RISE_RST, spFall: SP_FALL_RST,
    rangeLo: RANGE_LO_RST, rangeHi: RANGE_HI_RST, alertLim: ALIM_RST,
    swOn: 1'b0, alarm: 1'b0, diagPrev: 1'b0, alertPrev: 1'b0,
    irqStat: 4'h0, irqMask: 4'h0, irq: 1'b0, menu: MENU_NONE, ui: UI_BROWSE,
    selVal: 3'h0, cursor: 2'h0, digits: 12'h000, disp: 12'h000, scroll: 1'b0,
    edit: 1'b0};
endpackage

//--- core/lspa_switch_alarm.sv
// Purpose: percent scaling, hysteresis switch, alarm output and local keys
// Assumes: sensor inputs and key pulses are synchronous to sys_clk
// Notes: registers on classic Wishbone, one cycle wait state per access
// Operation
// - Alarm trigger: off, diagnosis, level, limit
// - Diagnosis trigger: range, temperature or memory fault
// - Level trigger follows logical output incl. inversion
// - Limit trigger: sensor above remote alarm limit
// - Make or break contact, make by default
// - Contact type change moves alarm output at once
// - Contact polarity separate from remote inversion
// - Switch on at rising point, default 55
// - Switch off at falling point, default 45
// - Low rising write drags falling point down
// - High falling write drags rising point up
// - Points and reading in percent 0..100
// - Rising point kept clear of measuring limits
// - Edit freezes value; up digit, down cursor
// - Six status text formats, numeric default
// - Language formats shown as scrolling text
// - Selections cycle with keys, mode stores
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module lspa_switch_alarm
  import lspa_pkg::*;
#(
  parameter logic [CNT_W-1:0] SENS_MIN = 16'h0010,
  parameter logic [CNT_W-1:0] SENS_MAX = 16'hfff0
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire lspa_wb_req_t wbReq,
  output logic wbAck,
  output logic [31:0] wbDatO,
  input wire lspa_sense_t sense,
  input wire lspa_keys_t keys,
  output logic alarmOut,
  output logic switchState,
  output logic irq,
  output logic [11:0] dispBcd,
  output logic dispEdit,
  output logic [1:0] dispCursor,
  output logic textScroll
);

  lspa_state_t st;
  lspa_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [11:0] toBcd(input logic [PCT_W-1:0] v);
    logic [PCT_W-1:0] rem;
    rem = (v >= PCT_FULL) ? PCT_ZERO : v;
    return {(v >= PCT_FULL) ? 4'h1 : 4'h0, 4'(rem / 7'd10), 4'(rem % 7'd10)};
  endfunction

  function automatic logic [PCT_W-1:0] fromBcd(input logic [11:0] d);
    logic [10:0] v;
    v = 11'(d[11:8]) * 11'd100 + 11'(d[7:4]) * 11'd10 + 11'(d[3:0]);
    return (v > 11'(PCT_FULL)) ? PCT_FULL : v[PCT_W-1:0];
  endfunction

  // Returns {rise, fall}; rising point bounded away from both limits
  function automatic logic [13:0] setRise(input logic [PCT_W-1:0] v,
                                          input logic [PCT_W-1:0] fall);
    logic [PCT_W-1:0] r;
    r = (v < RISE_MIN) ? RISE_MIN : (v > RISE_MAX) ? RISE_MAX : v;
    return {r, (r < fall) ? r : fall};
  endfunction

  // Falling point capped so a dragged rising point stays legal
  function automatic logic [13:0] setFall(input logic [PCT_W-1:0] v,
                                          input logic [PCT_W-1:0] rise);
    logic [PCT_W-1:0] f;
    f = (v > RISE_MAX) ? RISE_MAX : v;
    return {(f > rise) ? f : rise, f};
  endfunction

  function automatic logic [2:0] stepSel(input lspa_menu_t m, input logic [2:0] v,
                                         input logic up);
    logic [2:0] lim;
    lim = (m == MENU_TRIG) ? SEL_LIM_TRIG :
          (m == MENU_CONTACT) ? SEL_LIM_CONTACT : SEL_LIM_TEXT;
    if (up) begin
      return (v >= lim) ? 3'h0 : v + 3'h1;
    end
    return (v == 3'h0 || v > lim) ? lim : v - 3'h1;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (d & m);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Scaling to percent of the application range
  logic [CNT_W-1:0] cnt;
  logic [23:0] num;
  logic [23:0] den;
  logic [23:0] quo;
  logic [PCT_W-1:0] pct;
  logic diagCause;
  logic alertCause;
  logic cause;

  assign cnt = sense.count;
  assign num = 24'(cnt - st.rangeLo) * 24'(PCT_FULL);
  assign den = 24'(st.rangeHi - st.rangeLo);
  // Degenerate range ends in the clamp branches, never in the divide
  assign quo = (den == 24'h0) ? 24'h0 : num / den;
  assign pct = (cnt <= st.rangeLo) ? PCT_ZERO :
               (cnt >= st.rangeHi) ? PCT_FULL : quo[PCT_W-1:0];

  assign diagCause = (cnt < SENS_MIN) || (cnt > SENS_MAX) ||
                     sense.tempFault || sense.memFault;
  assign alertCause = cnt > st.alertLim;

  always_comb begin
    unique case (st.trig)
      TRIG_OFF: cause = 1'b0;
      TRIG_DIAGNOSIS_TRIGGER_SELECT: cause = diagCause;
      TRIG_LEVEL: cause = st.swOn ^ st.inv;
      TRIG_ALERT: cause = alertCause;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  logic take;
  logic [31:0] rdata;
  logic [31:0] ctrlWord;
  logic [31:0] wval;
  logic [13:0] pts;
  logic [IRQ_N-1:0] events;
  logic [IRQ_N-1:0] rdClr;
  logic [2:0] curSel;
  logic [3:0] dPos;

  assign take = wbReq.cyc && wbReq.stb && st.ack;
  assign ctrlWord = {25'h0, st.fmt, st.inv, st.brk, st.trig};
  // Cursor 0 is the hundreds digit, so the store follows the ones digit
  assign dPos = 4'(4 * (CURSOR_LAST - st.cursor));

  always_comb begin
    unique case (st.menu)
      MENU_TRIG: curSel = {1'b0, st.trig};
      MENU_CONTACT: curSel = {2'h0, st.brk};
      default: curSel = st.fmt;
    endcase
  end

  always_comb begin
    unique case (wbReq.adr)
      OFS_CTRL: rdata = ctrlWord;
      OFS_RISE: rdata = {25'h0, st.spRise};
      OFS_FALL: rdata = {25'h0, st.spFall};
      OFS_RLO: rdata = {16'h0, st.rangeLo};
      OFS_RHI: rdata = {16'h0, st.rangeHi};
      OFS_ALIM: rdata = {16'h0, st.alertLim};
      OFS_STAT: rdata = {17'h0, pct, 2'h0, st.ui, alertCause, diagCause, st.alarm,
                         st.swOn};
      OFS_ISTAT: rdata = {28'h0, st.irqStat};
      OFS_IMASK: rdata = {28'h0, st.irqMask};
      OFS_MENU: rdata = {29'h0, st.menu};
      default: rdata = 32'h0000_0000;
    endcase
  end

  always_comb begin
    next_st = st;
    wval = 32'h0000_0000;
    pts = {st.spRise, st.spFall};
    // Hysteresis switch
    if (pct >= st.spRise) begin
      next_st.swOn = 1'b1;
    end else if (pct <= st.spFall) begin
      next_st.swOn = 1'b0;
    end

    // Wishbone slave: ack one wait state later, write at the ack edge
    next_st.ack = wbReq.cyc && wbReq.stb && !st.ack;
    if (wbReq.cyc && wbReq.stb && !st.ack) begin
      next_st.datOut = rdata;
    end
    // Only bits actually returned are cleared, so nothing is lost
    rdClr = (take && !wbReq.we && wbReq.adr == OFS_ISTAT) ? st.datOut[IRQ_N-1:0] : '0;

    // Local keys
    unique case (st.ui)
      UI_BROWSE: begin
        if (keys.up || keys.down) begin
          if (st.menu == MENU_RISE || st.menu == MENU_FALL) begin
            next_st.ui = UI_LIVE;
          end else if (st.menu != MENU_NONE) begin
            next_st.ui = UI_SELECT;
            next_st.selVal = stepSel(st.menu, curSel, keys.up);
          end
        end
      end
      UI_LIVE: begin
        if (keys.mode) begin
          next_st.ui = UI_BROWSE;
        end else if (keys.up || keys.down) begin
          next_st.ui = UI_EDIT;
          next_st.digits = toBcd(pct);
          next_st.cursor = 2'h0;
        end
      end
      UI_EDIT: begin
        if (keys.mode) begin
          next_st.ui = UI_BROWSE;
        end else if (keys.up) begin
          next_st.digits[dPos +: 4] = (st.digits[dPos +: 4] >= DIGIT_MAX) ?
                                      4'h0 : st.digits[dPos +: 4] + 4'h1;
        end else if (keys.down) begin
          if (st.cursor == CURSOR_LAST) begin
            next_st.ui = UI_BROWSE;
            pts = (st.menu == MENU_RISE) ? setRise(fromBcd(st.digits), st.spFall) :
                  setFall(fromBcd(st.digits), st.spRise);
          end else begin
            next_st.cursor = st.cursor + 2'h1;
          end
        end
      end
      UI_SELECT: begin
        if (keys.mode) begin
          next_st.ui = UI_BROWSE;
          unique case (st.menu)
            MENU_TRIG: next_st.trig = lspa_trig_t'(st.selVal[1:0]);
            MENU_CONTACT: next_st.brk = st.selVal[0];
            default: next_st.fmt = lspa_fmt_t'(st.selVal);
          endcase
        end else if (keys.up || keys.down) begin
          next_st.selVal = stepSel(st.menu, st.selVal, keys.up);
        end
      end
    endcase

    // Bus writes take priority over a key action in the same cycle
    if (take && wbReq.we) begin
      unique case (wbReq.adr)
        OFS_CTRL: begin
          wval = merge(ctrlWord, wbReq.dat, wbReq.sel);
          next_st.trig = lspa_trig_t'(wval[CTRL_TRIG_LO +: 2]);
          next_st.brk = wval[CTRL_BRK];
          next_st.inv = wval[CTRL_INV];
          if (wval[CTRL_FMT_LO +: 3] <= SEL_LIM_TEXT) begin
            next_st.fmt = lspa_fmt_t'(wval[CTRL_FMT_LO +: 3]);
          end
        end
        OFS_RISE: begin
          wval = merge({25'h0, st.spRise}, wbReq.dat, wbReq.sel);
          pts = setRise((wval[31:PCT_W] != '0) ? PCT_FULL : wval[PCT_W-1:0], st.spFall);
        end
        OFS_FALL: begin
          wval = merge({25'h0, st.spFall}, wbReq.dat, wbReq.sel);
          pts = setFall((wval[31:PCT_W] != '0) ? PCT_FULL : wval[PCT_W-1:0], st.spRise);
        end
        OFS_RLO: begin
          wval = merge({16'h0, st.rangeLo}, wbReq.dat, wbReq.sel);
          next_st.rangeLo = wval[CNT_W-1:0];
        end
        OFS_RHI: begin
          wval = merge({16'h0, st.rangeHi}, wbReq.dat, wbReq.sel);
          next_st.rangeHi = wval[CNT_W-1:0];
        end
        OFS_ALIM: begin
          wval = merge({16'h0, st.alertLim}, wbReq.dat, wbReq.sel);
          next_st.alertLim = wval[CNT_W-1:0];
        end
        OFS_IMASK: begin
          wval = merge({28'h0, st.irqMask}, wbReq.dat, wbReq.sel);
          next_st.irqMask = wval[IRQ_N-1:0];
        end
        OFS_MENU: begin
          wval = merge({29'h0, st.menu}, wbReq.dat, wbReq.sel);
          if (wval[2:0] <= MENU_TEXT) begin
            next_st.menu = lspa_menu_t'(wval[2:0]);
            next_st.ui = UI_BROWSE;
          end
        end
        default: begin
        end
      endcase
    end
    next_st.spRise = pts[13:7];
    next_st.spFall = pts[6:0];

    // Alarm: contact polarity applied after trigger and inversion
    next_st.alarm = cause ^ st.brk;

    // Sticky events; a set in the clearing cycle wins
    events = '0;
    events[IRQ_SW_ON] = next_st.swOn && !st.swOn;
    events[IRQ_SW_OFF] = !next_st.swOn && st.swOn;
    events[IRQ_DIAGNOSIS_TRIGGER_SELECT] = diagCause && !st.diagPrev;
    events[IRQ_ALERT] = alertCause && !st.alertPrev;
    next_st.diagPrev = diagCause;
    next_st.alertPrev = alertCause;
    next_st.irqStat = (st.irqStat & ~rdClr) | events;
    next_st.irq = |(next_st.irqStat & next_st.irqMask);

    // Display content
    unique case (next_st.ui)
      UI_LIVE: next_st.disp = toBcd(pct);
      UI_EDIT: next_st.disp = next_st.digits;
      UI_SELECT: next_st.disp = {9'h0, next_st.selVal};
      UI_BROWSE: next_st.disp = (next_st.menu == MENU_FALL) ? toBcd(next_st.spFall) :
                                toBcd(next_st.spRise);
    endcase
    next_st.scroll = next_st.fmt != FMT_NUMERIC;
    next_st.edit = next_st.ui == UI_EDIT;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  assign wbAck = st.ack;
  assign wbDatO = st.datOut;
  assign alarmOut = st.alarm;
  assign switchState = st.swOn;
  assign irq = st.irq;
  assign dispBcd = st.disp;
  assign dispEdit = st.edit;
  assign dispCursor = st.cursor;
  assign textScroll = st.scroll;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  property p_diagnosis_trigger_select_alarm;
    st.trig == TRIG_DIAGNOSIS_TRIGGER_SELECT && diagCause |=> alarmOut == !$past(st.brk);
  endproperty
  a_diagnosis_trigger_select_alarm: assert property (p_diagnosis_trigger_select_alarm) else $error("diagnosis_trigger_select alarm wrong");

  property p_level_alarm;
    st.trig == TRIG_LEVEL |=> alarmOut == ($past(st.swOn) ^ $past(st.inv) ^ $past(st.brk));
  endproperty
  a_level_alarm: assert property (p_level_alarm) else $error("level alarm wrong");

  property p_alert_alarm;
    st.trig == TRIG_ALERT && cnt > st.alertLim |=> alarmOut == !$past(st.brk);
  endproperty
  a_alert_alarm: assert property (p_alert_alarm) else $error("limit alarm wrong");

  property p_off_alarm;
    st.trig == TRIG_OFF ##1 $stable(st.brk) |-> alarmOut == st.brk;
  endproperty
  a_off_alarm: assert property (p_off_alarm) else $error("disabled alarm wrong");

  property p_contact_now;
    $changed(st.brk) && $stable(cause) |=> $changed(alarmOut);
  endproperty
  a_contact_now: assert property (p_contact_now) else $error("contact lag");

  property p_rise_on;
    pct >= st.spRise |=> switchState;
  endproperty
  a_rise_on: assert property (p_rise_on) else $error("no switch on");

  property p_fall_off;
    pct <= st.spFall && pct < st.spRise |=> !switchState;
  endproperty
  a_fall_off: assert property (p_fall_off) else $error("no switch off");

  property p_order;
    st.spRise >= st.spFall && st.spRise >= RISE_MIN && st.spRise <= RISE_MAX;
  endproperty
  a_order: assert property (p_order) else $error("switch points out of order");

  property p_pct_range;
    pct <= PCT_FULL;
  endproperty
  a_pct_range: assert property (p_pct_range) else $error("percent above full");

  property p_hold;
    pct > st.spFall && pct < st.spRise |=> switchState == $past(switchState);
  endproperty
  a_hold: assert property (p_hold) else $error("hysteresis lost");

  property p_freeze;
    dispEdit && !keys.up && !keys.down && !keys.mode |=> $stable(dispBcd);
  endproperty
  a_freeze: assert property (p_freeze) else $error("edit value moved");

  property p_scroll;
    ##1 textScroll == ($past(next_st.fmt) != FMT_NUMERIC) && st.fmt <= FMT_IT;
  endproperty
  a_scroll: assert property (p_scroll) else $error("scroll flag wrong");

  property p_irq;
    irq == |(st.irqStat & st.irqMask);
  endproperty
  a_irq: assert property (p_irq) else $error("irq level wrong");

endmodule
`default_nettype wire

//--- verification/lspa_probe_model.sv
// Purpose: probe front end and push-buttons in front of the switch logic
// Assumes: count and fault flags are synchronous levels
// Notes: keys are one-cycle pulses, paced by the caller
`timescale 1ns/1ps
`default_nettype none
module lspa_probe_model
  import lspa_pkg::*;
(
  input wire logic sys_clk,
  output var lspa_sense_t sense,
  output var lspa_keys_t keys
);
  initial begin
    sense = '{count: 16'h0190, tempFault: 1'b0, memFault: 1'b0};
    keys = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic setLevel(input logic [CNT_W-1:0] c, input logic t, input logic m);
    @(posedge sys_clk);
    sense <= '{count: c, tempFault: t, memFault: m};
  endtask

  // Idle cycles before the press model a slow operator
  task automatic press(input logic [2:0] k, input int gap);
    repeat (gap) @(posedge sys_clk);
    @(posedge sys_clk);
    keys <= k;
    @(posedge sys_clk);
    keys <= '0;
  endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Purpose: register and key level checks of the switch and alarm logic
// Assumes: range 0..1000 counts, so percent is count divided by ten
// Notes: settle waits follow the registered latencies in the hand-over
`timescale 1ns/1ps
`default_nettype none
module testbench
  import lspa_pkg::*;
();
  logic sys_clk;
  logic resetn;
  lspa_wb_req_t wbReq;
  logic wbAck;
  logic [31:0] wbDatO;
  lspa_sense_t sense;
  lspa_keys_t keys;
  logic alarmOut;
  logic switchState;
  logic irq;
  logic [11:0] dispBcd;
  logic dispEdit;
  logic [1:0] dispCursor;
  logic textScroll;
  int nFail = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] rd;

  lspa_switch_alarm u_dut (
    .sys_clk(sys_clk), .resetn(resetn), .wbReq(wbReq), .wbAck(wbAck),
    .wbDatO(wbDatO), .sense(sense), .keys(keys), .alarmOut(alarmOut),
    .switchState(switchState), .irq(irq), .dispBcd(dispBcd),
    .dispEdit(dispEdit), .dispCursor(dispCursor), .textScroll(textScroll)
  );
  lspa_probe_model u_probe (.sys_clk(sys_clk), .sense(sense), .keys(keys));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("TB: checks %0d failures %0d", checked, nFail);
    if (nFail == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Generous ceiling: the sequence needs well under 2000 cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      nFail++;
      finish_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      nFail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Classic single cycle: request held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge sys_clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
    do begin
      @(posedge sys_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    rd = wbDatO;
    wbReq <= '0;
    chk("bus_ack", {31'h0, wbAck}, 32'h1);
  endtask

  task automatic rdchk(input string name, input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    chk(name, rd, exp);
  endtask

  task automatic key(input logic [2:0] k);
    u_probe.press(k, 1);
    #1;
  endtask

  task automatic level(input logic [15:0] c, input logic t, input logic m);
    u_probe.setLevel(c, t, m);
    settle(4);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] hCnt [6] = '{16'h021c, 16'h0226, 16'h01cc, 16'h01c2, 16'h021c, 16'h0230};
  logic hExp [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  logic [31:0] cCtl [6] = '{32'h2, 32'h6, 32'ha, 32'he, 32'h0, 32'h4};
  logic cExp [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  logic [31:0] dCtl [7] = '{32'h1, 32'h1, 32'h1, 32'h1, 32'h1, 32'h3, 32'h3};
  logic [17:0] dIn [7] = '{{16'h0226, 2'b00}, {16'h0226, 2'b10}, {16'h0226, 2'b01},
    {16'h0005, 2'b00}, {16'hfffa, 2'b00}, {16'h0258, 2'b00}, {16'h0259, 2'b00}};
  logic dExp [7] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};

  initial begin
    resetn = 1'b0;
    wbReq = '0;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    settle(2);
    chk("alarm_rst", {31'h0, alarmOut}, 32'h0);
    rdchk("ctrl_rst", OFS_CTRL, 32'h1);
    rdchk("rise_rst", OFS_RISE, 32'h37);
    rdchk("fall_rst", OFS_FALL, 32'h2d);
    rdchk("unmapped", 8'h30, 32'h0);
    chk("scroll_rst", {31'h0, textScroll}, 32'h0);
    wb(1'b1, OFS_RLO, 32'h0);
    wb(1'b1, OFS_RHI, 32'h3e8);
    rdchk("istat_clr", OFS_ISTAT, 32'h0);
    wb(1'b1, OFS_IMASK, 32'h1);
    for (int i = 0; i < 6; i++) begin
      level(hCnt[i], 1'b0, 1'b0);
      chk("switch", {31'h0, switchState}, {31'h0, hExp[i]});
    end
    chk("irq_on", {31'h0, irq}, 32'h1);
    rdchk("status", OFS_STAT, 32'h3801);
    rdchk("istat_ev", OFS_ISTAT, 32'h3);
    settle(1);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    wb(1'b1, OFS_IMASK, 32'h0);
    level(16'h0190, 1'b0, 1'b0);
    chk("irq_mask", {31'h0, irq}, 32'h0);
    rdchk("istat_off", OFS_ISTAT, 32'h2);
    // Switch is off here; contact and inversion combine separately
    for (int i = 0; i < 6; i++) begin
      wb(1'b1, OFS_CTRL, cCtl[i]);
      settle(1);
      chk("contact", {31'h0, alarmOut}, {31'h0, cExp[i]});
    end
    wb(1'b1, OFS_CTRL, 32'h2);
    level(16'h02bc, 1'b0, 1'b0);
    chk("level_trig", {31'h0, alarmOut}, 32'h1);
    wb(1'b1, OFS_ALIM, 32'h258);
    for (int i = 0; i < 7; i++) begin
      wb(1'b1, OFS_CTRL, dCtl[i]);
      level(dIn[i][17:2], dIn[i][1], dIn[i][0]);
      chk("cause", {31'h0, alarmOut}, {31'h0, dExp[i]});
    end
    wb(1'b1, OFS_RISE, 32'h1e);
    rdchk("fall_drag", OFS_FALL, 32'h1e);
    wb(1'b1, OFS_FALL, 32'h46);
    rdchk("rise_drag", OFS_RISE, 32'h46);
    wb(1'b1, OFS_RISE, 32'h0);
    rdchk("rise_min", OFS_RISE, 32'h1);
    wb(1'b1, OFS_RISE, 32'h64);
    rdchk("rise_max", OFS_RISE, 32'h63);
    for (int f = 0; f < 6; f++) begin
      wb(1'b1, OFS_CTRL, 32'h1 | (f << 4));
      settle(1);
      chk("scroll", {31'h0, textScroll}, {31'h0, f != 0});
    end
    wb(1'b1, OFS_CTRL, 32'h61);
    rdchk("fmt_keep", OFS_CTRL, 32'h51);
    level(16'h0226, 1'b0, 1'b0);
    wb(1'b1, OFS_MENU, 32'h3);
    key(3'b100);
    chk("live", {20'h0, dispBcd}, 32'h55);
    key(3'b100);
    chk("edit", {31'h0, dispEdit}, 32'h1);
    level(16'h02bc, 1'b0, 1'b0);
    chk("frozen", {20'h0, dispBcd}, 32'h55);
    key(3'b010);
    chk("cursor", {30'h0, dispCursor}, 32'h1);
    key(3'b100);
    chk("digit", {20'h0, dispBcd}, 32'h65);
    key(3'b010);
    chk("cursor_last", {30'h0, dispCursor}, 32'h2);
    key(3'b100);
    chk("ones", {20'h0, dispBcd}, 32'h66);
    key(3'b010);
    chk("stored", {31'h0, dispEdit}, 32'h0);
    rdchk("rise_key", OFS_RISE, 32'h42);
    wb(1'b1, OFS_CTRL, 32'h1);
    wb(1'b1, OFS_MENU, 32'h1);
    key(3'b100);
    chk("candidate", {20'h0, dispBcd}, 32'h2);
    key(3'b100);
    key(3'b100);
    key(3'b010);
    key(3'b001);
    rdchk("trig_key", OFS_CTRL, 32'h3);
    wb(1'b1, OFS_MENU, 32'h2);
    key(3'b100);
    key(3'b001);
    settle(1);
    chk("contact_key", {31'h0, alarmOut}, 32'h0);
    rdchk("ctrl_key", OFS_CTRL, 32'h7);
    finish_test();
  end
endmodule
`default_nettype wire
